// [core/wdtps_top.sv]
`timescale 1ns/1ps
//Contract
// R1 - source: internal oscillator or system clock/4
// R2 - counter overflow generates a reset
// R3 - disabled watchdog makes its instructions no-ops
// R4 - first divide source by 256, eight stages
// R5 - three-bit scale field, all ones gives 1:128
// R6 - prescale ratio is two to scale value
// R7 - instruction-clock source stops during power down
// R8 - normal time-out resets device, sets timeout flag
// R9 - power-down time-out resets only PC and SP
// R10 - reset pin, clear or halt clears counters
// R11 - option picks single or paired clear scheme
// R12 - single scheme: each clear instruction clears
// R13 - paired: after first, only second clears
// R14 - paired: after second, only first clears
// R15 - noisy systems should use internal oscillator
// R16 - halt clears watchdog, sets powerdown, clears timeout
// R17 - powerdown flag: set by halt, cleared by clears
module wdtps_top
	import wdtps_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               wdt_osc_in,
	input  wire logic               external_reset_pin_n,
	input  wire logic               cfg_wdt_en,
	input  wire logic               cfg_src_osc,
	input  wire logic               cfg_pair_clear,
	input  wire logic [PSR_W-1:0]   prescale_select_reg,
	input  wire logic               single_clear_instr,
	input  wire logic               clear_first_half_instr,
	input  wire logic               clear_second_half_instr,
	input  wire logic               halt_instr,
	input  wire logic               wake_evt,
	output logic                    device_reset,
	output logic                    pc_sp_reset,
	output logic                    timeout_flag,
	output logic                    powerdown_flag,
	output logic                    power_down,
	output logic [CNT_W-1:0]        wdt_count
);
	logic                   rst_s1_r;
	logic                   rst_n;
	logic                   osc_s1_r;
	logic                   osc_s2_r;
	logic                   osc_s3_r;
	logic                   ext_s1_r;
	logic                   ext_s2_r;
	logic [INSTR_DIV_W-1:0] div_r;
	logic                   osc_tick;
	logic                   instr_tick;
	logic                   ext_rst_active;
	logic                   halt_go;
	logic                   sw_clear;
	logic                   wdt_clear;
	logic                   device_reset_r;
	logic                   pc_sp_reset_r;
	logic                   timeout_flag_r;
	logic                   powerdown_flag_r;
	logic                   power_down_r;
	logic [CNT_W-1:0]       wdt_count_r;

	wdtps_cnt_if cnt_bus ();

	// reset release is synchronised; assertion stays asynchronous
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// oscillator pin is asynchronous: two stages, then edge detect on the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else begin
			osc_s1_r <= wdt_osc_in;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	assign osc_tick = osc_s2_r && !osc_s3_r;

	// external reset pin, synchronised; idles high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_r <= 1'b1;
			ext_s2_r <= 1'b1;
		end else begin
			ext_s1_r <= external_reset_pin_n;
			ext_s2_r <= ext_s1_r;
		end
	end

	assign ext_rst_active = !ext_s2_r;

	// instruction clock divider; frozen in power down as the system clock stops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= INSTR_DIV_RST;
		end else if (!power_down_r) begin
			div_r <= div_r + 2'h1; // [R1]
		end
	end

	assign instr_tick = (div_r == INSTR_DIV_LAST) && !power_down_r; // [R7]

	// a second halt while already halted cannot be executed
	assign halt_go = halt_instr && !power_down_r;

	wdtps_clear_seq u_clear_seq (
		.clk                     (clk),
		.rst_n                   (rst_n),
		.enable                  (cfg_wdt_en),
		.pair_mode               (cfg_pair_clear),
		.single_clear_instr      (single_clear_instr),
		.clear_first_half_instr  (clear_first_half_instr),
		.clear_second_half_instr (clear_second_half_instr),
		.clear_pulse             (sw_clear)
	);

	// disabled watchdog is held cleared so it can never time out
	assign wdt_clear = !cfg_wdt_en || ext_rst_active || sw_clear || halt_go; // [R10] [R16]

	// oscillator keeps running through halt, so it still guards power down
	assign cnt_bus.tick  = cfg_wdt_en && (cfg_src_osc ? osc_tick : instr_tick); // [R1]
	assign cnt_bus.clear = wdt_clear;
	assign cnt_bus.scale = prescale_select_reg[SCALE_LSB +: SCALE_W]; // [R5]

	wdtps_counter u_counter (
		.clk (clk),
		.rst_n (rst_n),
		.cnt (cnt_bus.cnt)
	);

	// time-out effect depends on whether the device is halted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			device_reset_r <= 1'b0;
			pc_sp_reset_r  <= 1'b0;
		end else begin
			device_reset_r <= cnt_bus.timeout && !power_down_r; // [R2] [R8]
			pc_sp_reset_r  <= cnt_bus.timeout && power_down_r; // [R9]
		end
	end

	// power-down state: entered by halt, left on any wake source
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_down_r <= 1'b0;
		end else if (ext_rst_active || cnt_bus.timeout || wake_evt) begin
			power_down_r <= 1'b0;
		end else if (halt_go) begin
			power_down_r <= 1'b1; // [R16]
		end
	end

	// set wins over clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timeout_flag_r <= TIMEOUT_FLAG_RST;
		end else if (cnt_bus.timeout) begin
			timeout_flag_r <= 1'b1; // [R8] [R9]
		end else if (halt_go) begin
			timeout_flag_r <= 1'b0; // [R16]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			powerdown_flag_r <= POWERDOWN_FLAG_RST; // [R17]
		end else if (halt_go) begin
			powerdown_flag_r <= 1'b1; // [R16] [R17]
		end else if (sw_clear) begin
			powerdown_flag_r <= 1'b0; // [R17]
		end
	end

	// registered copy so the top output comes straight from a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_count_r <= CNT_RST;
		end else begin
			wdt_count_r <= cnt_bus.count;
		end
	end

	assign device_reset   = device_reset_r;
	assign pc_sp_reset    = pc_sp_reset_r;
	assign timeout_flag   = timeout_flag_r;
	assign powerdown_flag = powerdown_flag_r;
	assign power_down     = power_down_r;
	assign wdt_count      = wdt_count_r;
endmodule

// [common/wdtps_pkg.sv]
package wdtps_pkg;
	// nominal oscillator and base time-out, for reference only; neither the logic nor the bench uses them
	localparam int WDT_OSC_PERIOD_US = 78;
	localparam int BASE_TIMEOUT_MS   = 20;
	localparam int MAX_TIMEOUT_MS    = 2600;

	// instruction clock is the system clock divided by 4
	localparam int         INSTR_DIV     = 4;
	localparam int         INSTR_DIV_W   = 2;
	localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);
	localparam logic [1:0] INSTR_DIV_RST = 2'h0;

	// fixed divide-by-256 stage followed by a 1:1..1:128 prescaler
	localparam int STAGE_BITS = 8;
	localparam int PRESC_BITS = 7;
	localparam int CNT_W      = STAGE_BITS + PRESC_BITS;
	localparam logic [CNT_W:0]   STAGE_SPAN = 16'h0100;
	localparam logic [CNT_W-1:0] CNT_RST    = 15'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE    = 15'h0001;

	// timeout scale field inside the prescale select register
	localparam int SCALE_LSB = 0;
	localparam int SCALE_W   = 3;
	localparam int PSR_W     = 8;

	// flag reset values at power-up
	localparam logic TIMEOUT_FLAG_RST   = 1'b0;
	localparam logic POWERDOWN_FLAG_RST = 1'b0;

	typedef enum logic [1:0] {
		WDTPS_PAIR_IDLE,
		WDTPS_PAIR_GOT_FIRST,
		WDTPS_PAIR_GOT_SECOND
	} wdtps_pair_t;
endpackage

// [common/wdtps_cnt_if.sv]
`timescale 1ns/1ps
interface wdtps_cnt_if;
	import wdtps_pkg::*;
	logic                 tick;
	logic                 clear;
	logic [SCALE_W-1:0]   scale;
	logic                 timeout;
	logic [CNT_W-1:0]     count;

	modport ctl (
		output tick,
		output clear,
		output scale,
		input  timeout,
		input  count
	);
	modport cnt (
		input  tick,
		input  clear,
		input  scale,
		output timeout,
		output count
	);
endinterface

// [core/wdtps_counter.sv]
`timescale 1ns/1ps
module wdtps_counter
	import wdtps_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	wdtps_cnt_if.cnt  cnt
);
	logic [CNT_W:0]   span;
	logic [CNT_W-1:0] last;
	logic [CNT_W-1:0] count_r;
	logic             timeout_r;

	// 8-stage divide-by-256, then prescale of two to the scale value
	always_comb begin
		span = STAGE_SPAN << cnt.scale; // [R4] [R5] [R6]
		last = span[CNT_W-1:0] - CNT_ONE;
	end

	// clear beats a tick arriving in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= CNT_RST;
		end else if (cnt.clear) begin
			count_r <= CNT_RST; // [R10]
		end else if (cnt.tick) begin
			if (count_r >= last) begin
				count_r <= CNT_RST;
			end else begin
				count_r <= count_r + CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timeout_r <= 1'b0;
		end else begin
			timeout_r <= !cnt.clear && cnt.tick && (count_r >= last); // [R2]
		end
	end

	assign cnt.count   = count_r;
	assign cnt.timeout = timeout_r;
endmodule

// [core/wdtps_clear_seq.sv]
`timescale 1ns/1ps
module wdtps_clear_seq
	import wdtps_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic pair_mode,
	input  wire logic single_clear_instr,
	input  wire logic clear_first_half_instr,
	input  wire logic clear_second_half_instr,
	output logic      clear_pulse
);
	wdtps_pair_t state_r;
	wdtps_pair_t state_nxt;
	logic        pair_clear;

	always_comb begin
		state_nxt  = state_r;
		pair_clear = 1'b0;
		unique case (state_r)
			WDTPS_PAIR_IDLE: begin
				if (clear_first_half_instr) begin
					state_nxt = WDTPS_PAIR_GOT_FIRST;
				end else if (clear_second_half_instr) begin
					state_nxt = WDTPS_PAIR_GOT_SECOND;
				end
			end
			WDTPS_PAIR_GOT_FIRST: begin
				// repeated first half is ignored
				if (clear_second_half_instr) begin
					pair_clear = 1'b1; // [R13]
					state_nxt  = WDTPS_PAIR_IDLE;
				end
			end
			WDTPS_PAIR_GOT_SECOND: begin
				if (clear_first_half_instr) begin
					pair_clear = 1'b1; // [R14]
					state_nxt  = WDTPS_PAIR_IDLE;
				end
			end
			default: begin
				state_nxt = WDTPS_PAIR_IDLE;
			end
		endcase
	end

	// half-done sequence is dropped when the scheme or enable changes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= WDTPS_PAIR_IDLE;
		end else if (!enable || !pair_mode) begin
			state_r <= WDTPS_PAIR_IDLE; // [R3]
		end else begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		if (!enable) begin
			clear_pulse = 1'b0; // [R3]
		end else if (pair_mode) begin
			clear_pulse = pair_clear; // [R11]
		end else begin
			clear_pulse = single_clear_instr; // [R11] [R12]
		end
	end
endmodule

// [test/wdtps_props.sv]
`timescale 1ns/1ps
module wdtps_props
	import wdtps_pkg::*;
(
	input wire logic             clk,
	input wire logic             resetn,
	input wire logic             external_reset_pin_n,
	input wire logic             cfg_wdt_en,
	input wire logic             cfg_pair_clear,
	input wire logic             single_clear_instr,
	input wire logic             halt_instr,
	input wire logic             device_reset,
	input wire logic             pc_sp_reset,
	input wire logic             timeout_flag,
	input wire logic             powerdown_flag,
	input wire logic             power_down,
	input wire logic [CNT_W-1:0] wdt_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_pulse; device_reset |=> !device_reset; endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	property p_toset; device_reset |-> timeout_flag; endproperty
	a_toset: assert property (p_toset) else $error("flag not set");
	property p_pdrst; pc_sp_reset |-> $past(power_down) && !power_down; endproperty
	a_pdrst: assert property (p_pdrst) else $error("pc reset outside halt");
	property p_devrst; device_reset |-> !$past(power_down); endproperty
	a_devrst: assert property (p_devrst) else $error("full reset in halt");
	property p_halt;
		halt_instr && !power_down |=> power_down && powerdown_flag && !timeout_flag;
	endproperty
	a_halt: assert property (p_halt) else $error("halt effects wrong");
	property p_single;
		cfg_wdt_en && !cfg_pair_clear && single_clear_instr |-> ##2 wdt_count == CNT_RST;
	endproperty
	a_single: assert property (p_single) else $error("clear missed");
	property p_dis; !cfg_wdt_en |-> ##2 (wdt_count == CNT_RST && !device_reset); endproperty
	a_dis: assert property (p_dis) else $error("disabled but counting");
	property p_pin; !external_reset_pin_n [*3] |-> ##2 wdt_count == CNT_RST; endproperty
	a_pin: assert property (p_pin) else $error("pin did not clear");
endmodule
bind wdtps_top wdtps_props u_props (.clk, .resetn, .external_reset_pin_n, .cfg_wdt_en,
	.cfg_pair_clear, .single_clear_instr, .halt_instr, .device_reset, .pc_sp_reset,
	.timeout_flag, .powerdown_flag, .power_down, .wdt_count);

// [test/watchdog_timer_with_prescaler_tb_top.sv]
`timescale 1ns/1ps
module watchdog_timer_with_prescaler_tb_top;
	import wdtps_pkg::*;
	logic             clk, resetn, osc, ext_n, en, src, pair, sc, c1, c2, halt, wake;
	logic             dev, pcsp, to_f, pd_f, pd;
	logic [PSR_W-1:0] psr;
	logic [CNT_W-1:0] cnt;
	logic [31:0]      r;
	logic [31:0]      seed = 32'h00014478;
	int               failures, comparisons, n_dev, n_pcsp, n, m, s, e;
	// oscillator half period in clk cycles; the time-out window is derived from it
	localparam int    OSC_HALF = 4;
	wdtps_top dut (.clk(clk), .resetn(resetn), .wdt_osc_in(osc), .external_reset_pin_n(ext_n),
		.cfg_wdt_en(en), .cfg_src_osc(src), .cfg_pair_clear(pair), .prescale_select_reg(psr),
		.single_clear_instr(sc), .clear_first_half_instr(c1), .clear_second_half_instr(c2),
		.halt_instr(halt), .wake_evt(wake), .device_reset(dev), .pc_sp_reset(pcsp),
		.timeout_flag(to_f), .powerdown_flag(pd_f), .power_down(pd), .wdt_count(cnt));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int ticks(int sc_v);
		return INSTR_DIV * (int'(STAGE_SPAN) << sc_v);
	endfunction
	task automatic chk(input logic [15:0] a, input logic [15:0] x);
		@(negedge clk);
		comparisons++;
		if (a !== x) begin
			failures++;
			$display("mismatch t=%0t got %h exp %h", $time, a, x);
		end
	endtask
	task automatic ins(input int k);
		@(posedge clk);
		case (k)
			0: sc <= 1'b1;
			1: c1 <= 1'b1;
			2: c2 <= 1'b1;
			default: halt <= 1'b1;
		endcase
		@(posedge clk);
		{sc, c1, c2, halt} <= 4'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic conclude();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// slow enough that the high phase spans the synchroniser
	initial begin
		osc = 1'b0;
		forever begin
			wt(OSC_HALF);
			osc <= ~osc;
		end
	end
	always @(negedge clk) begin
		if (dev === 1'b1) n_dev++;
		if (pcsp === 1'b1) n_pcsp++;
	end
	initial begin
		wt(60000);
		failures++;
		conclude();
	end
	initial begin
		{resetn, en, src, pair, psr, sc, c1, c2, halt, wake} = '0;
		ext_n = 1'b1;
		en = 1'b1;
		wt(3);
		resetn <= 1'b1;
		wt(3);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			r = rnd();
			s = int'(r % 3);
			psr <= {r[7:3], 3'(s)};
			ins(0);
			e = ticks(s);
			n = 3;
			while (dev !== 1'b1 && n < e + 20) begin
				@(negedge clk);
				n++;
			end
			chk(16'(n > e - 8 && n < e + 8), 16'h0001);
			chk(16'(to_f), 16'h0001);
		end
		$display("test timeout done");
		@(posedge clk);
		psr <= 8'hF8;
		n = n_dev;
		repeat (3) begin
			wt(650 + int'(rnd() % 50));
			ins(0);
		end
		chk(16'(n_dev - n), 16'h0000);
		// full scale: count must run well past the base stage without a reset
		@(posedge clk);
		psr <= 8'h07;
		ins(0);
		wt(2000);
		chk(16'(cnt > 2000 / INSTR_DIV - 8 && cnt < 2000 / INSTR_DIV + 8), 16'h0001);
		chk(16'(n_dev - n), 16'h0000);
		@(posedge clk);
		psr <= 8'hF8;
		pair <= 1'b1;
		ext_n <= 1'b0;
		wt(4);
		ext_n <= 1'b1;
		chk(16'(cnt), 16'h0000);
		wt(300);
		ins(0);
		chk(16'(cnt > 50), 16'h0001);
		ins(1);
		chk(16'(cnt > 50), 16'h0001);
		ins(1);
		chk(16'(cnt > 50), 16'h0001);
		ins(2);
		chk(16'(cnt < 4), 16'h0001);
		wt(300);
		ins(2);
		chk(16'(cnt > 50), 16'h0001);
		ins(1);
		chk(16'(cnt < 4), 16'h0001);
		$display("test paired done");
		@(posedge clk);
		pair <= 1'b0;
		src <= 1'b1;
		ins(0);
		ins(3);
		chk(16'({pd, pd_f, to_f}), 16'h0006);
		n = n_dev;
		m = n_pcsp;
		s = 2 * OSC_HALF * int'(STAGE_SPAN);
		for (e = 0; e < 3000 && n_pcsp == m; e++) @(negedge clk);
		chk(16'(n_pcsp - m), 16'h0001);
		chk(16'(e > s - 16 && e < s + 16), 16'h0001);
		chk(16'(n_dev - n), 16'h0000);
		chk(16'(pd), 16'h0000);
		@(posedge clk);
		src <= 1'b0;
		ins(3);
		wt(2500);
		chk(16'(n_pcsp - m), 16'h0001);
		chk(16'(n_dev - n), 16'h0000);
		chk({pd, cnt}, 16'h8000);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		en <= 1'b0;
		ins(0);
		chk(16'(pd_f), 16'h0001);
		wt(1500);
		chk(16'(n_dev - n), 16'h0000);
		chk(16'(cnt), 16'h0000);
		@(posedge clk);
		en <= 1'b1;
		ins(0);
		chk(16'(pd_f), 16'h0000);
		$display("test power down done");
		// power-up in mid-run must drop the flags that a halt has set
		ins(3);
		chk(16'({pd, pd_f}), 16'h0003);
		@(posedge clk);
		resetn <= 1'b0;
		wt(3);
		resetn <= 1'b1;
		wt(3);
		chk(16'({pd, pd_f, to_f, dev, pcsp}), 16'h0000);
		$display("test reset done");
		conclude();
	end
endmodule
